// File: hdl/alarm_relay_output_control.sv
// alarm relay output control: channel alarms, logic functions, APB registers, interrupt
// assumes readings synchronous to clock and an APB3 master; pready is always high
//
// Our own choices: the register addresses and the APB interface to the registers.
`default_nettype none
module alarm_relay_output_control
	import relay_pkg::*;
#(
	parameter int CHANNELS    = 8,
	parameter int OUTPUTS     = 2,
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic [11:0]                paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output var  logic [31:0]                prdata,
	output var  logic                       pready,
	output var  logic                       pslverr,
	input  wire logic [CHANNELS-1:0][15:0]  reading,
	output var  logic [OUTPUTS-1:0]         relayClosed,
	output var  logic                       irq
);
	// ****************************************************************
	// address layout
	// ****************************************************************
	localparam logic [9:0] OUT_WORDS  = 10'(OUTPUTS * 4);
	localparam logic [9:0] ALM_FIRST  = ALARM_BASE_OFS[11:2];
	localparam logic [9:0] ALM_LAST   = 10'(ALARM_BASE_OFS[11:2] + 10'(CHANNELS * 2));

	typedef struct packed {
		logic [OUTPUTS-1:0][31:0]        outCtrl;
		logic [OUTPUTS-1:0][31:0]        outDelay;
		logic [OUTPUTS-1:0][31:0]        outHold;
		logic [CHANNELS-1:0][1:0][31:0]  alarmCfg;
		logic [CHANNELS-1:0][1:0]        alarm;
		logic [OUTPUTS-1:0]              irqStat;
		logic [OUTPUTS-1:0]              irqMask;
		logic [31:0]                     tickCnt;
		logic                            tick;
		logic [31:0]                     rdata;
		logic                            slvErr;
	} state_t;

	state_t              st;
	state_t              next_st;
	logic [OUTPUTS-1:0]  fnVal;
	logic [OUTPUTS-1:0]  activeVec;
	logic [OUTPUTS-1:0]  changedVec;
	logic [9:0]          widx;
	logic                isOut;
	logic                isAlm;
	logic [1:0]          outIdx;
	logic [1:0]          outReg;
	logic [9:0]          almIdx;
	logic [2:0]          almCh;
	logic                almSel;
	logic                setupPhase;
	logic                writeAccess;
	logic [31:0]         relayWord;
	logic [31:0]         alarmWord;

	// ****************************************************************
	// alarm condition with hysteresis
	// ****************************************************************
	function automatic logic alarmNext(input logic prev, input logic [15:0] rd, input logic [31:0] cfg);
		logic signed [17:0] v;
		logic signed [17:0] thr;
		logic signed [17:0] hys;
		logic signed [17:0] upper;
		logic signed [17:0] lower;
		logic               res;
		v     = 18'(signed'(rd));
		thr   = 18'(signed'(cfg[ALM_THR_POS +: 16]));
		hys   = signed'({3'b000, cfg[ALM_HYS_POS +: 15]});
		upper = thr + hys;
		lower = thr - hys;
		res   = prev;
		if (cfg[ALM_OVER_BIT]) begin
			if (v >= upper) begin
				res = 1'b1;
			end else if (v <= lower) begin
				res = 1'b0;
			end
		end else begin
			if (v <= lower) begin
				res = 1'b1;
			end else if (v >= upper) begin
				res = 1'b0;
			end
		end
		return res;
	endfunction

	// ****************************************************************
	// logic function of one output
	// ****************************************************************
	function automatic logic outFunction(input logic [31:0] ctrl, input logic [CHANNELS-1:0][1:0] alm);
		logic anyHit;
		logic allHit;
		logic attached;
		logic hit;
		anyHit   = 1'b0;
		allHit   = 1'b1;
		attached = 1'b0;
		hit      = 1'b0;
		for (int ch = 0; ch < CHANNELS; ch++) begin
			case (source_t'(ctrl[CTRL_SRC_POS + 2 * ch +: 2]))
				SRC_FIRST: begin
					hit = alm[ch][0];
				end
				SRC_SECOND: begin
					hit = alm[ch][1];
				end
				SRC_BOTH: begin
					hit = alm[ch][0] & alm[ch][1];
				end
				default: begin
					hit = 1'b0;
				end
			endcase
			if (ctrl[CTRL_SRC_POS + 2 * ch +: 2] != 2'h0) begin
				attached = 1'b1;
				anyHit   = anyHit | hit;
				allHit   = allHit & hit;
			end
		end
		// an output with nothing attached never asserts
		return ctrl[CTRL_AND_BIT] ? (attached & allHit) : anyHit;
	endfunction

	// ****************************************************************
	// address decode
	// ****************************************************************
	assign widx        = paddr[11:2];
	assign isOut       = widx < OUT_WORDS && widx[1:0] != 2'h3;
	assign outIdx      = widx[3:2];
	assign outReg      = widx[1:0];
	assign isAlm       = widx >= ALM_FIRST && widx < ALM_LAST;
	assign almIdx      = widx - ALM_FIRST;
	assign almCh       = almIdx[3:1];
	assign almSel      = almIdx[0];
	assign setupPhase  = psel & ~penable;
	assign writeAccess = psel & penable & pwrite;

	always_comb begin
		for (int o = 0; o < OUTPUTS; o++) begin
			fnVal[o] = outFunction(st.outCtrl[o], st.alarm);
		end
	end

	// ****************************************************************
	// status words
	// ****************************************************************
	always_comb begin
		relayWord                           = '0;
		alarmWord                           = '0;
		relayWord[OUTPUTS-1:0]              = relayClosed;
		relayWord[RSTAT_ACT_POS +: OUTPUTS] = activeVec;
		for (int ch = 0; ch < CHANNELS; ch++) begin
			alarmWord[ch]                = st.alarm[ch][0];
			alarmWord[ASTAT_A2_POS + ch] = st.alarm[ch][1];
		end
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic [31:0] rd;
		logic        err;
		rd      = '0;
		err     = 1'b0;
		next_st = st;

		// ************************************************************
		// tenth-second tick
		// ************************************************************
		if (st.tickCnt >= 32'(TICK_CYCLES - 1)) begin
			next_st.tickCnt = '0;
			next_st.tick    = 1'b1;
		end else begin
			next_st.tickCnt = st.tickCnt + 32'h0000_0001;
			next_st.tick    = 1'b0;
		end

		// ************************************************************
		// two alarms per channel
		// ************************************************************
		for (int ch = 0; ch < CHANNELS; ch++) begin
			for (int a = 0; a < 2; a++) begin
				next_st.alarm[ch][a] = alarmNext(st.alarm[ch][a], reading[ch], st.alarmCfg[ch][a]);
			end
		end

		// ************************************************************
		// register read, captured in the setup phase
		// ************************************************************
		if (isOut) begin
			case (outReg)
				OUT_CTRL_IDX: begin
					rd = st.outCtrl[outIdx];
				end
				OUT_DELAY_IDX: begin
					rd = st.outDelay[outIdx];
				end
				OUT_HOLD_IDX: begin
					rd = st.outHold[outIdx];
				end
				default: begin
					err = 1'b1;
				end
			endcase
		end else if (isAlm) begin
			rd = st.alarmCfg[almCh][almSel];
		end else begin
			case (paddr)
				IRQ_STAT_OFS: begin
					rd = 32'(st.irqStat);
				end
				IRQ_MASK_OFS: begin
					rd = 32'(st.irqMask);
				end
				RELAY_STAT_OFS: begin
					rd = relayWord;
				end
				ALARM_STAT_OFS: begin
					rd = alarmWord;
				end
				default: begin
					err = 1'b1;
				end
			endcase
		end
		if (setupPhase) begin
			next_st.rdata  = pwrite ? 32'h0000_0000 : rd;
			next_st.slvErr = err;
		end

		// ************************************************************
		// register write, taken in the access phase
		// ************************************************************
		if (writeAccess && !st.slvErr) begin
			if (isOut) begin
				case (outReg)
					OUT_CTRL_IDX: begin
						next_st.outCtrl[outIdx] = pwdata;
					end
					OUT_DELAY_IDX: begin
						next_st.outDelay[outIdx] = pwdata;
					end
					OUT_HOLD_IDX: begin
						next_st.outHold[outIdx] = pwdata;
					end
					default: begin
					end
				endcase
			end else if (isAlm) begin
				next_st.alarmCfg[almCh][almSel] = pwdata;
			end else if (paddr == IRQ_MASK_OFS) begin
				next_st.irqMask = pwdata[OUTPUTS-1:0];
			end
		end

		// ************************************************************
		// sticky relay-change events; a new event wins over a clear
		// ************************************************************
		if (writeAccess && !st.slvErr && paddr == IRQ_STAT_OFS) begin
			next_st.irqStat = st.irqStat & ~pwdata[OUTPUTS-1:0];
		end
		next_st.irqStat = next_st.irqStat | changedVec;
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st          <= '0;
			st.outCtrl  <= {OUTPUTS{OUT_CTRL_RST}};
			st.outDelay <= {OUTPUTS{OUT_DELAY_RST}};
			st.outHold  <= {OUTPUTS{OUT_HOLD_RST}};
			st.alarmCfg <= {(2 * CHANNELS){ALARM_CFG_RST}};
			st.irqMask  <= IRQ_MASK_RST[OUTPUTS-1:0];
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// relay output controllers
	// ****************************************************************
	for (genvar o = 0; o < OUTPUTS; o++) begin : g_out
		relay_out_if ifc ();
		assign ifc.fn         = fnVal[o];
		assign ifc.tick       = st.tick;
		assign ifc.nc         = st.outCtrl[o][CTRL_NC_BIT];
		assign ifc.closeDelay = st.outDelay[o][TIME_LO_POS +: 16];
		assign ifc.openDelay  = st.outDelay[o][TIME_HI_POS +: 16];
		assign ifc.closedHold = st.outHold[o][TIME_LO_POS +: 16];
		assign ifc.openHold   = st.outHold[o][TIME_HI_POS +: 16];
		assign relayClosed[o] = ifc.closed;
		assign activeVec[o]   = ifc.active;
		assign changedVec[o]  = ifc.changed;
		relay_output u_out (
			.clock (clock),
			.rst_n (rst_n),
			.port  (ifc.unit)
		);
	end

	// ****************************************************************
	// bus answers
	// ****************************************************************
	assign prdata  = st.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & st.slvErr;

	// ****************************************************************
	// interrupt
	// ****************************************************************
	assign irq     = |(st.irqStat & st.irqMask);
endmodule
`default_nettype wire

// File: hdl/relay_pkg.sv
// register map, field layout, reset values and timing for the alarm relay block
// assumes a single 40 MHz clock and an APB master with 32-bit data
`default_nettype none
package relay_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLOCK_PERIOD_NS = 25;
	localparam int TICK_TIME_NS    = 100_000_000;
	localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLOCK_PERIOD_NS;

	// ****************************************************************
	// register offsets (byte addresses) and word indices inside an output's block
	// ****************************************************************
	localparam logic [11:0] OUT_BASE_OFS   = 12'h000;
	localparam logic [11:0] OUT_STRIDE     = 12'h010;
	localparam logic [1:0]  OUT_CTRL_IDX   = 2'h0;
	localparam logic [1:0]  OUT_DELAY_IDX  = 2'h1;
	localparam logic [1:0]  OUT_HOLD_IDX   = 2'h2;
	localparam logic [11:0] IRQ_STAT_OFS   = 12'h040;
	localparam logic [11:0] IRQ_MASK_OFS   = 12'h044;
	localparam logic [11:0] RELAY_STAT_OFS = 12'h048;
	localparam logic [11:0] ALARM_STAT_OFS = 12'h04C;
	localparam logic [11:0] ALARM_BASE_OFS = 12'h080;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_NC_BIT   = 0;
	localparam int CTRL_AND_BIT  = 1;
	localparam int CTRL_SRC_POS  = 16;
	localparam int ALM_THR_POS   = 0;
	localparam int ALM_HYS_POS   = 16;
	localparam int ALM_OVER_BIT  = 31;
	localparam int TIME_LO_POS   = 0;
	localparam int TIME_HI_POS   = 16;
	localparam int RSTAT_ACT_POS = 8;
	localparam int ASTAT_A2_POS  = 8;

	// ****************************************************************
	// channel source encodings
	// ****************************************************************
	typedef enum logic [1:0] {SRC_NONE, SRC_FIRST, SRC_SECOND, SRC_BOTH} source_t;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [31:0] OUT_CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] OUT_DELAY_RST = 32'h0000_0000;
	localparam logic [31:0] OUT_HOLD_RST  = 32'h0000_0000;
	localparam logic [31:0] ALARM_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] IRQ_MASK_RST  = 32'h0000_0000;
endpackage
`default_nettype wire

// File: hdl/relay_out_if.sv
// carrier between the top and one relay output controller
// assumes both ends sit in the same clock domain
`default_nettype none
interface relay_out_if;
	logic        fn;
	logic        tick;
	logic        nc;
	logic [15:0] closeDelay;
	logic [15:0] openDelay;
	logic [15:0] closedHold;
	logic [15:0] openHold;
	logic        closed;
	logic        active;
	logic        changed;

	modport top  (output fn, tick, nc, closeDelay, openDelay, closedHold, openHold,
	              input closed, active, changed);
	modport unit (input fn, tick, nc, closeDelay, openDelay, closedHold, openHold,
	              output closed, active, changed);
endinterface
`default_nettype wire

// File: hdl/relay_output.sv
// one relay output: delay counter, hold timer and polarity
// assumes tick is a one-cycle pulse every tenth of a second
`default_nettype none
module relay_output
	import relay_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	relay_out_if.unit port
);
	typedef struct packed {
		logic        active;
		logic        closed;
		logic        holding;
		logic        changed;
		logic [15:0] cnt;
		logic [15:0] holdCnt;
	} unit_t;

	unit_t st;
	unit_t next_st;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic        want;
		logic        flip;
		logic [15:0] delay;
		logic [15:0] hold;
		want    = 1'b0;
		flip    = 1'b0;
		delay   = '0;
		hold    = '0;
		next_st = st;
		next_st.changed = 1'b0;
		if (st.holding) begin
			// hold running: alarm state and delay counting frozen
			if (port.tick) begin
				if (st.holdCnt <= 16'h0001) begin
					next_st.holding = 1'b0;
					next_st.cnt     = '0;
				end else begin
					next_st.holdCnt = st.holdCnt - 16'h0001;
				end
			end
		end else begin
			want  = port.fn != st.active;
			delay = st.active ? port.openDelay : port.closeDelay;
			if (want && delay == 16'h0000) begin
				flip = 1'b1;
			end else if (port.tick) begin
				if (want) begin
					if ({1'b0, st.cnt} + 17'h00001 >= {1'b0, delay}) begin
						flip = 1'b1;
					end else begin
						next_st.cnt = st.cnt + 16'h0001;
					end
				end else if (st.cnt != 16'h0000) begin
					next_st.cnt = st.cnt - 16'h0001;
				end
			end
		end
		if (flip) begin
			next_st.active  = ~st.active;
			next_st.cnt     = '0;
			next_st.changed = 1'b1;
			hold = (~st.active ^ port.nc) ? port.closedHold : port.openHold;
			if (hold != 16'h0000) begin
				next_st.holding = 1'b1;
				next_st.holdCnt = hold;
			end
		end
		// N.O. closes on 1, N.C. opens on 1
		next_st.closed = next_st.active ^ port.nc;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign port.closed  = st.closed;
	assign port.active  = st.active;
	assign port.changed = st.changed;
endmodule
`default_nettype wire

// File: bench/alarm_relay_output_control_asserts.sv
// port-level checker for the alarm relay output block
// assumes the top module's own ports and one clock domain
`default_nettype none
module alarm_relay_output_control_asserts
	import relay_pkg::*;
#(
	parameter int CHANNELS = 8,
	parameter int OUTPUTS  = 2
)
(
	input wire logic                      clock,
	input wire logic                      rst_n,
	input wire logic [11:0]               paddr,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [31:0]               pwdata,
	input wire logic [31:0]               prdata,
	input wire logic                      pready,
	input wire logic                      pslverr,
	input wire logic [CHANNELS-1:0][15:0] reading,
	input wire logic [OUTPUTS-1:0]        relayClosed,
	input wire logic                      irq
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// bus and interrupt relations
	// ****
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_err_phase: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	chk_err_unmapped: assert property (psel && penable && paddr >= 12'h100 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_map_ok: assert property (psel && penable && paddr[11:4] == 8'h04 |-> !pslverr)
		else $error("status access refused");
	chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside setup");
	chk_irq_cause: assert property ($rose(irq) |->
		$past(psel && penable && pwrite) || $past(relayClosed) != $past(relayClosed, 2))
		else $error("irq rose without relay change or write");
	chk_irq_drop: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
		else $error("irq fell without write");
	chk_reset_relays: assert property (disable iff (1'b0) !rst_n |=> relayClosed == '0 && !irq)
		else $error("relays or irq not cleared by reset");
endmodule

bind alarm_relay_output_control alarm_relay_output_control_asserts #(
	.CHANNELS(CHANNELS), .OUTPUTS(OUTPUTS)) checker_inst (
	.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.reading(reading), .relayClosed(relayClosed), .irq(irq));
`default_nettype wire

// File: bench/relay_load.sv
// model of the external relays: counts each change of relayClosed; contacts that change together count once
// assumes relayClosed drives the coils directly, so a glitch is a switch
`default_nettype none
module relay_load #(
	parameter int OUTPUTS = 2
)
(
	input  wire logic [OUTPUTS-1:0] relayClosed,
	output var  int                 switches
);
	timeunit 1ns;
	timeprecision 100ps;
	int count = 0;
	// ****
	// contact changes
	// ****
	always @(relayClosed) begin
		count = count + 1;
	end
	assign switches = count;
endmodule
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the alarm relay output block
// assumes a fast tick of 8 cycles and two outputs over eight channels
`default_nettype none
module testbench
	import relay_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int T = 8;
	logic             clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd, ctrl;
	logic [7:0][15:0] reading, vec;
	logic [1:0]       relayClosed;
	int               err_count, check_count, cycles, seed, switches, n, base;
	int               thr[16], hys[16];
	logic             ovr[16], alm[16];
	logic [11:0]      ra[5] = '{OUT_BASE_OFS, 12'h004, 12'h008, IRQ_MASK_OFS, 12'h100};
	logic [31:0]      rv[5] = '{OUT_CTRL_RST, OUT_DELAY_RST, OUT_HOLD_RST, IRQ_MASK_RST, 32'h0};

	alarm_relay_output_control #(.CHANNELS(8), .OUTPUTS(2), .TICK_CYCLES(T)) alarm_relay_output_control_inst (
		.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reading(reading), .relayClosed(relayClosed), .irq(irq));
	relay_load #(.OUTPUTS(2)) relay_load_inst (.relayClosed(relayClosed), .switches(switches));

	// ****
	// expectations
	// ****
	function automatic logic nextAlm(input logic p, input int r, t, h, input logic o);
		if (o)
			return r >= t + h ? 1'b1 : (r <= t - h ? 1'b0 : p);
		return r <= t - h ? 1'b1 : (r >= t + h ? 1'b0 : p);
	endfunction
	function automatic logic expRelay(input logic [31:0] c);
		logic x, any, all, att;
		any = 0;
		all = 1;
		att = 0;
		for (int i = 0; i < 8; i++) if (c[16+2*i+:2] != 2'h0) begin
			x = (!c[16+2*i] | alm[2*i]) & (!c[17+2*i] | alm[2*i+1]);
			att = 1;
			any |= x;
			all &= x;
		end
		return (c[1] ? att & all : any) ^ c[0];
	endfunction

	// ****
	// tasks
	// ****
	task results;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task checkVal(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task checkRange(input int v, input int lo, input int hi);
		check_count++;
		if (v < lo || v > hi) begin
			err_count++;
			$display("wrong value at %0t: %0d cycles not in %0d..%0d", $time, v, lo, hi);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task setAll(input logic [15:0] v);
		@(posedge clock);
		reading <= {8{v}};
	endtask
	task waitRelay(input logic e);
		n = 0;
		base = switches;
		while (relayClosed[0] !== e && n < 400) begin
			@(negedge clock);
			n++;
		end
		checkVal(32'(switches - base), 32'h1);
	endtask

	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end

	// ****
	// scenarios
	// ****
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, reading} = '0;
		seed = 32;
		repeat (16) @(posedge clock);
		rst_n <= 1;
		for (int i = 0; i < 5; i++) begin
			apb(0, ra[i], 32'h0);
			checkVal(rd, rv[i]);
			checkVal(er, 32'(i == 4));
		end
		for (int a = 0; a < 16; a++) begin
			thr[a] = $random(seed) % 50;
			hys[a] = 1 + ($random(seed) & 15);
			ovr[a] = $random(seed);
			apb(1, ALARM_BASE_OFS + 12'(4 * a), {ovr[a], 15'(hys[a]), 16'(thr[a])});
		end
		for (int k = 0; k < 25; k++) begin
			for (int c = 0; c < 8; c++) vec[c] = k == 0 ? 16'h7FFF : 16'($random(seed) % 70);
			@(posedge clock);
			reading <= vec;
			repeat (3) @(posedge clock);
			for (int a = 0; a < 16; a++) alm[a] = nextAlm(alm[a], int'($signed(vec[a/2])), thr[a], hys[a], ovr[a]);
			apb(0, ALARM_STAT_OFS, 32'h0);
			for (int c = 0; c < 8; c++) checkVal({rd[8+c], rd[c]}, {alm[2*c+1], alm[2*c]});
		end
		for (int k = 0; k < 20; k++) begin
			ctrl = {16'($random(seed)), 14'h0, 2'(k)};
			if (k == 2) for (int i = 0; i < 8; i++) ctrl[16+2*i+:2] = alm[2*i+1] ? 2'h2 : {1'b0, alm[2*i]};
			apb(1, OUT_BASE_OFS, ctrl);
			apb(1, OUT_STRIDE, ctrl);
			repeat (3) @(negedge clock);
			checkVal(relayClosed, {2{expRelay(ctrl)}});
		end
		apb(1, ALARM_BASE_OFS, {1'b1, 15'd5, 16'd100});
		apb(1, OUT_BASE_OFS, 32'h0001_0000);
		apb(1, OUT_STRIDE, 32'h0);
		setAll(16'hFF38);
		repeat (4) @(posedge clock);
		apb(1, IRQ_STAT_OFS, 32'hF);
		apb(1, IRQ_MASK_OFS, 32'h1);
		setAll(16'd200);
		waitRelay(1'b1);
		checkRange(n, 1, 4);
		repeat (2) @(negedge clock);
		checkVal(irq, 32'h1);
		apb(1, IRQ_MASK_OFS, 32'h0);
		@(negedge clock);
		checkVal(irq, 32'h0);
		apb(1, IRQ_MASK_OFS, 32'h1);
		@(negedge clock);
		checkVal(irq, 32'h1);
		apb(0, IRQ_STAT_OFS, 32'h0);
		checkVal(rd, 32'h1);
		apb(1, IRQ_STAT_OFS, 32'h1);
		@(negedge clock);
		checkVal(irq, 32'h0);
		apb(1, OUT_BASE_OFS + 12'h4, 32'h2);
		apb(1, OUT_BASE_OFS + 12'h8, 32'h3);
		setAll(16'hFF38);
		waitRelay(1'b0);
		setAll(16'd200);
		repeat (7) @(posedge clock);
		setAll(16'hFF38);
		repeat (20) @(posedge clock);
		setAll(16'd200);
		waitRelay(1'b1);
		checkRange(n, T + 2, 2 * T + 2);
		setAll(16'hFF38);
		waitRelay(1'b0);
		checkRange(n, 2 * T, 3 * T + 3);
		apb(1, OUT_BASE_OFS + 12'h4, 32'h0001_0000);
		apb(1, OUT_BASE_OFS + 12'h8, 32'h0002_0000);
		setAll(16'd200);
		waitRelay(1'b1);
		checkRange(n, 1, 4);
		setAll(16'hFF38);
		waitRelay(1'b0);
		checkRange(n, 3, T + 2);
		setAll(16'd200);
		waitRelay(1'b1);
		checkRange(n, 2 * T, 2 * T + 2);
		results();
	end
endmodule
`default_nettype wire
